/* tcc_timer.sv */
// Purpose: 16-bit timer counter with capture/compare/PWM channels behind APB
// Assumes: pclk 25 MHz; pins and external clock are asynchronous
// Notes:   Channels pair as (0,1), (2,3) and so on up to NUM_CH; even channel can run buffered
//
// Design decisions made here: the address map and the APB slave port.
`include "tcc_defs.svh"
`timescale 1ns/1ps

module tcc_timer #(
	parameter int NUM_CH = 4
) (
	input  wire  logic              pclk,         // Bus clock
	input  wire  logic              presetn,      // Async reset, active low
	input  wire  logic              psel,         // APB select
	input  wire  logic              penable,      // APB enable
	input  wire  logic              pwrite,       // APB direction
	input  wire  logic [7:0]        paddr,        // APB byte address
	input  wire  logic [31:0]       pwdata,       // APB write data
	output logic       [31:0]       prdata,       // APB read data
	output logic                    pready,       // APB ready
	output logic                    pslverr,      // Unmapped address
	input  wire  logic              break_active, // Debug break state
	input  wire  logic              ext_clk_pin,  // External timer clock
	input  wire  logic [NUM_CH-1:0] ch_pin_in,    // Channel pin levels
	output logic       [NUM_CH-1:0] ch_pin_out,   // Channel drive level
	output logic       [NUM_CH-1:0] ch_pin_oe_n,  // Low while driving
	output logic       [NUM_CH-1:0] ch_irq        // Channel requests
);
	import tcc_pkg::*;

	localparam int NPAIR = NUM_CH / 2;

	if (NUM_CH < 2 || NUM_CH > 12 || (NUM_CH % 2) != 0)
	begin : g_bad_num_ch
		$error("NUM_CH must be even and between 2 and 12");
	end

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic logic addr_ok(input logic [7:0] a);
		logic [7:0] off;
		off = a - `TCC_OFF_CH_BASE;
		if (a < `TCC_OFF_CH_BASE)
			return a == `TCC_OFF_TIMER_CTRL || a == `TCC_OFF_COUNT_HI ||
				a == `TCC_OFF_COUNT_LO || a == `TCC_OFF_MOD_HI || a == `TCC_OFF_MOD_LO;
		return (int'(off >> `TCC_CH_STRIDE_SHIFT) < NUM_CH) && (off[3:0] == `TCC_SUB_STATUS ||
			off[3:0] == `TCC_SUB_VALUE_HI || off[3:0] == `TCC_SUB_VALUE_LO);
	endfunction : addr_ok

	function automatic logic ch_hit(input logic [7:0] a, input int n, input logic [3:0] sub);
		return a == 8'(`TCC_OFF_CH_BASE + (n << `TCC_CH_STRIDE_SHIFT)) + {4'h0, sub};
	endfunction : ch_hit

	// Odd channel is dropped when its even partner runs buffered
	function automatic tcc_mode_e chan_mode(input int n, input tcc_ctrl_s c, input tcc_ctrl_s p);
		if ((n % 2) == 1 && p.buffered_mode_select)
			return TCC_GPIO;
		if ({c.edge_level_select_hi, c.edge_level_select_lo} == 2'b00)
			return TCC_GPIO;
		if ((n % 2) == 0 && c.buffered_mode_select)
			return TCC_BUFFERED;
		return c.capture_compare_select ? TCC_COMPARE : TCC_CAPTURE;
	endfunction : chan_mode

	// ****************************************************************
	// State
	// ****************************************************************
	logic        [NUM_CH-1:0] pin_s1, pin_s2, pin_s3;
	logic                     ext_s1, ext_s2, ext_s3;
	logic                     halt, next_halt;
	logic        [2:0]        ps, next_ps;
	logic        [6:0]        presc, next_presc;
	logic        [15:0]       cnt, next_cnt;
	logic        [15:0]       modv, next_modv;
	tcc_ctrl_s                ctrl [NUM_CH];
	tcc_ctrl_s                next_ctrl [NUM_CH];
	tcc_value_s               val [NUM_CH];
	tcc_value_s               next_val [NUM_CH];
	logic        [NUM_CH-1:0] arm, next_arm, cap_blk, next_cap_blk;
	logic        [NUM_CH-1:0] cmp_blk, next_cmp_blk, lvl, next_lvl;
	logic        [NUM_CH-1:0] max_eff, next_max_eff, next_out, next_oe_n, next_irq;
	logic        [NPAIR-1:0]  act_odd, next_act_odd, last_odd, next_last_odd;
	logic        [31:0]       next_prdata;
	logic                     next_pslverr;
	tcc_mode_e                mode [NUM_CH];
	logic        [NUM_CH-1:0] cap_ev, match_ev, wr_stat;
	logic                     tick, run, ovf, clr_wr;

	assign pready = 1'b1;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb
	begin
		logic       setup, rd, wr, rise, fall, drive, sw_only;
		logic [6:0] mask;
		tcc_value_s cv;
		setup = psel && !penable;
		rd = psel && penable && !pwrite;
		wr = psel && penable && pwrite;
		rise = 1'b0;
		fall = 1'b0;
		drive = 1'b0;
		sw_only = 1'b0;
		cv = '0;
		mask = 7'((8'h01 << ps) - 8'h01);
		tick = (ps == `TCC_PS_EXT) ? (ext_s2 && !ext_s3) : ((presc & mask) == mask);
		run = tick && !halt && !break_active;
		ovf = run && (cnt == modv);
		clr_wr = wr && paddr == `TCC_OFF_TIMER_CTRL && pwdata[`TCC_BIT_CLEAR];
		next_halt = halt;
		next_ps = ps;
		next_modv = modv;
		next_presc = presc + 7'h01;
		next_cnt = cnt;
		if (run)
			next_cnt = ovf ? 16'h0000 : cnt + 16'h0001;
		if (wr && paddr == `TCC_OFF_TIMER_CTRL)
		begin
			next_halt = pwdata[`TCC_BIT_HALT];
			next_ps = pwdata[`TCC_PS_MSB:0];
		end
		if (clr_wr)
		begin
			next_cnt = 16'h0000;
			next_presc = 7'h00;
		end
		if (wr && paddr == `TCC_OFF_MOD_HI)
			next_modv[15:8] = pwdata[7:0];
		if (wr && paddr == `TCC_OFF_MOD_LO)
			next_modv[7:0] = pwdata[7:0];
		next_act_odd = act_odd;
		next_last_odd = last_odd;
		next_pslverr = setup ? !addr_ok(paddr) : pslverr;
		next_prdata = setup ? 32'h0000_0000 : prdata;
		if (setup)
		begin
			unique case (paddr)
				`TCC_OFF_TIMER_CTRL: next_prdata[7:0] = {2'b00, halt, 2'b00, ps};
				`TCC_OFF_COUNT_HI:   next_prdata[7:0] = cnt[15:8];
				`TCC_OFF_COUNT_LO:   next_prdata[7:0] = cnt[7:0];
				`TCC_OFF_MOD_HI:     next_prdata[7:0] = modv[15:8];
				`TCC_OFF_MOD_LO:     next_prdata[7:0] = modv[7:0];
				default:             next_prdata[7:0] = 8'h00;
			endcase
		end
		for (int n = 0; n < NUM_CH; n++)
		begin
			mode[n] = chan_mode(n, ctrl[n], ctrl[n ^ 1]);
			next_ctrl[n] = ctrl[n];
			next_val[n] = val[n];
			next_arm[n] = arm[n];
			next_cap_blk[n] = cap_blk[n];
			next_cmp_blk[n] = cmp_blk[n];
			next_lvl[n] = lvl[n];
			next_max_eff[n] = max_eff[n];
			wr_stat[n] = wr && ch_hit(paddr, n, `TCC_SUB_STATUS);
			if (setup && ch_hit(paddr, n, `TCC_SUB_STATUS))
				next_prdata[7:0] = ctrl[n];
			if (setup && ch_hit(paddr, n, `TCC_SUB_VALUE_HI))
				next_prdata[7:0] = val[n].hi;
			if (setup && ch_hit(paddr, n, `TCC_SUB_VALUE_LO))
				next_prdata[7:0] = val[n].lo;
			rise = pin_s2[n] && !pin_s3[n];
			fall = !pin_s2[n] && pin_s3[n];
			unique case ({ctrl[n].edge_level_select_hi, ctrl[n].edge_level_select_lo})
				2'b01:   cap_ev[n] = rise;
				2'b10:   cap_ev[n] = fall;
				2'b11:   cap_ev[n] = rise || fall;
				default: cap_ev[n] = 1'b0;
			endcase
			cap_ev[n] = cap_ev[n] && mode[n] == TCC_CAPTURE && !cap_blk[n] && !halt;
			// Buffered channel compares against whichever pair member is active
			cv = val[n];
			if (mode[n] == TCC_BUFFERED && act_odd[n / 2])
				cv = val[n | 1];
			drive = mode[n] == TCC_COMPARE || mode[n] == TCC_BUFFERED;
			sw_only = mode[n] == TCC_GPIO && ctrl[n].capture_compare_select &&
				!ctrl[n].buffered_mode_select;
			if ((n % 2) == 1 && ctrl[n ^ 1].buffered_mode_select)
				sw_only = 1'b0;
			match_ev[n] = (drive || sw_only) && run && cnt == {cv.hi, cv.lo} &&
				!cmp_blk[n] && !(mode[n] == TCC_BUFFERED && cmp_blk[n | 1]);
			if (cap_ev[n])
				next_val[n] = cnt;
			// Arm only on the read whose returned data showed the flag set
			if (rd && ch_hit(paddr, n, `TCC_SUB_STATUS))
				next_arm[n] = prdata[`TCC_BIT_FLAG];
			if (wr_stat[n])
			begin
				next_ctrl[n] = tcc_ctrl_s'(pwdata[7:0]);
				next_ctrl[n].channel_event_flag = ctrl[n].channel_event_flag;
				if ((n % 2) == 1)
					next_ctrl[n].buffered_mode_select = 1'b0;
				if (arm[n] && !pwdata[`TCC_BIT_FLAG])
					next_ctrl[n].channel_event_flag = 1'b0;
				next_arm[n] = 1'b0;
			end
			if (cap_ev[n] || match_ev[n])
			begin
				next_ctrl[n].channel_event_flag = 1'b1;
				next_arm[n] = 1'b0;
			end
			if (wr && ch_hit(paddr, n, `TCC_SUB_VALUE_HI))
			begin
				next_val[n].hi = pwdata[7:0];
				next_cmp_blk[n] = mode[n] != TCC_CAPTURE;
			end
			if (wr && ch_hit(paddr, n, `TCC_SUB_VALUE_LO))
			begin
				next_val[n].lo = pwdata[7:0];
				next_cmp_blk[n] = 1'b0;
				next_last_odd[n / 2] = (n % 2) == 1;
			end
			if (rd && ch_hit(paddr, n, `TCC_SUB_VALUE_HI) && mode[n] == TCC_CAPTURE)
				next_cap_blk[n] = 1'b1;
			if (rd && ch_hit(paddr, n, `TCC_SUB_VALUE_LO))
				next_cap_blk[n] = 1'b0;
			if (mode[n] == TCC_GPIO)
				next_lvl[n] = !ctrl[n].capture_compare_select;
			else if (drive && ovf && ctrl[n].overflow_toggle)
				next_lvl[n] = !lvl[n];
			else if (match_ev[n])
			begin
				unique case ({ctrl[n].edge_level_select_hi, ctrl[n].edge_level_select_lo})
					2'b01:   next_lvl[n] = !lvl[n];
					2'b10:   next_lvl[n] = 1'b0;
					2'b11:   next_lvl[n] = 1'b1;
					default: next_lvl[n] = lvl[n];
				endcase
			end
			// While driving, full duty only changes at a period boundary to avoid a runt pulse
			if (!drive)
				next_max_eff[n] = 1'b0;
			else if (ovf)
				next_max_eff[n] = ctrl[n].overflow_toggle && ctrl[n].full_duty_force;
			if (mode[n] == TCC_BUFFERED && ovf)
				next_act_odd[n / 2] = last_odd[n / 2];
			next_out[n] = next_max_eff[n] || next_lvl[n];
			next_oe_n[n] = !drive;
			next_irq[n] = next_ctrl[n].channel_event_flag && next_ctrl[n].channel_irq_enable;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{pin_s1, pin_s2, pin_s3} <= '0;
			{ext_s1, ext_s2, ext_s3} <= 3'h0;
			halt <= `TCC_RST_HALT;
			ps <= `TCC_RST_PS;
			presc <= 7'h00;
			cnt <= 16'h0000;
			modv <= `TCC_RST_MOD;
			for (int n = 0; n < NUM_CH; n++)
			begin
				ctrl[n] <= `TCC_RST_CTRL;
				val[n] <= `TCC_RST_VALUE;
			end
			{arm, cap_blk, cmp_blk, lvl, max_eff} <= '0;
			{act_odd, last_odd} <= '0;
			ch_pin_out <= '0;
			ch_pin_oe_n <= '1;
			ch_irq <= '0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pin_s1 <= ch_pin_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			ext_s1 <= ext_clk_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			halt <= next_halt;
			ps <= next_ps;
			presc <= next_presc;
			cnt <= next_cnt;
			modv <= next_modv;
			ctrl <= next_ctrl;
			val <= next_val;
			arm <= next_arm;
			cap_blk <= next_cap_blk;
			cmp_blk <= next_cmp_blk;
			lvl <= next_lvl;
			max_eff <= next_max_eff;
			act_odd <= next_act_odd;
			last_odd <= next_last_odd;
			ch_pin_out <= next_out;
			ch_pin_oe_n <= next_oe_n;
			ch_irq <= next_irq;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_OVF_RESTART: assert property (ovf && !clr_wr |=> cnt == 16'h0000)
		else $error("counter did not restart after overflow");
	AST_BREAK_FREEZE: assert property (break_active && !clr_wr |=> $stable(cnt))
		else $error("counter moved during break");

	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ast
		AST_CAPTURE: assert property (cap_ev[g] |=>
			ctrl[g].channel_event_flag && {val[g].hi, val[g].lo} == $past(cnt))
			else $error("capture did not store counter and set flag");
		AST_MATCH_FLAG: assert property (match_ev[g] |=> ctrl[g].channel_event_flag)
			else $error("compare match did not set flag");
		AST_CLEAR_SEQ: assert property ($fell(ctrl[g].channel_event_flag) |->
			$past(arm[g]) && $past(wr_stat[g]) && !$past(pwdata[7]))
			else $error("flag cleared without read-then-write-zero");
		AST_EVENT_WINS: assert property (wr_stat[g] && (cap_ev[g] || match_ev[g]) |=>
			ctrl[g].channel_event_flag)
			else $error("clearing write beat a new event");
		AST_IRQ: assert property (ch_irq[g] ==
			(ctrl[g].channel_event_flag && ctrl[g].channel_irq_enable))
			else $error("interrupt request disagrees with flag and enable");
		AST_CAP_BLOCK: assert property (cap_blk[g] || halt |-> !cap_ev[g])
			else $error("capture while blocked or halted");
		AST_CMP_BLOCK: assert property (cmp_blk[g] |-> !match_ev[g])
			else $error("compare while high byte write pending");
		AST_GPIO_RELEASE: assert property (mode[g] == TCC_GPIO |=> ch_pin_oe_n[g])
			else $error("pin driven while released to GPIO");
	end

endmodule : tcc_timer

/* tcc_defs.svh */
// Purpose: Offsets, field positions and reset values of the timer channel block
// Assumes: Byte addresses on an 8-bit APB address, one 32-bit word per register
// Notes:   Definitions only
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TCC_OFF_TIMER_CTRL   8'h00
`define TCC_OFF_COUNT_HI     8'h04
`define TCC_OFF_COUNT_LO     8'h08
`define TCC_OFF_MOD_HI       8'h0c
`define TCC_OFF_MOD_LO       8'h10
`define TCC_OFF_CH_BASE      8'h20
`define TCC_CH_STRIDE_SHIFT  4
`define TCC_SUB_STATUS       4'h0
`define TCC_SUB_VALUE_HI     4'h4
`define TCC_SUB_VALUE_LO     4'h8

// ****************************************************************
// Field positions of timer_control_status
// ****************************************************************
`define TCC_BIT_HALT         5
`define TCC_BIT_CLEAR        4
`define TCC_PS_MSB           2
`define TCC_PS_EXT           3'h7

// ****************************************************************
// Field positions of channel_control_status
// ****************************************************************
`define TCC_BIT_FLAG         7

// ****************************************************************
// Reset values
// ****************************************************************
`define TCC_RST_HALT         1'b1
`define TCC_RST_PS           3'h0
`define TCC_RST_MOD          16'hffff
`define TCC_RST_CTRL         8'h00
`define TCC_RST_VALUE        16'h0000

`endif

/* tcc_pkg.sv */
// Purpose: Types shared by the timer channel block
// Assumes: Nothing
// Notes:   Control byte layout matches the channel status register bit order
package tcc_pkg;

	// ****************************************************************
	// Channel control/status byte
	// ****************************************************************
	typedef struct packed {
		logic channel_event_flag;
		logic channel_irq_enable;
		logic buffered_mode_select;
		logic capture_compare_select;
		logic edge_level_select_hi;
		logic edge_level_select_lo;
		logic overflow_toggle;
		logic full_duty_force;
	} tcc_ctrl_s;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} tcc_value_s;

	typedef enum logic [1:0] {
		TCC_GPIO,
		TCC_CAPTURE,
		TCC_COMPARE,
		TCC_BUFFERED
	} tcc_mode_e;

endpackage : tcc_pkg

/* tcc_pin_model.sv */
// Purpose: Outside circuitry on the timer channel pins
// Assumes: Bench sets the level that the outside world drives
// Notes:   Block drive wins wherever its enable is low
`timescale 1ns/1ps

module tcc_pin_model #(
	parameter int NUM_CH = 4
) (
	input  wire logic [NUM_CH-1:0] ch_pin_out,  // Block drive level
	input  wire logic [NUM_CH-1:0] ch_pin_oe_n, // Low while block drives
	input  wire logic [NUM_CH-1:0] ext_level,   // Outside drive level
	output logic      [NUM_CH-1:0] pin_level    // Resolved wire level
);
	// Released pin falls back to the outside level
	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			pin_level[i] = ch_pin_oe_n[i] ? ext_level[i] : ch_pin_out[i];
		end
	end
endmodule : tcc_pin_model

/* tb_top.sv */
// Purpose: Self-checking bench for the timer channel block
// Assumes: Counter modulo 3f; bus waits for pready, however long
// Notes:   Pins resolved by the pin model, external clock driven by the bench
`include "tcc_defs.svh"
`timescale 1ns/1ps

module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        break_active;
	logic [3:0]  ext_level;
	logic [3:0]  pin_level;
	logic [3:0]  ch_pin_out;
	logic [3:0]  ch_pin_oe_n;
	logic [3:0]  ch_irq;
	logic [7:0]  q;
	logic [7:0]  q2;
	logic [7:0]  cfg;
	logic        last_err;
	logic        pin_before;
	logic        ext_clk;
	int          err_total = 0;
	int          n_compared = 0;

	tcc_timer #(.NUM_CH(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.break_active(break_active), .ext_clk_pin(ext_clk), .ch_pin_in(pin_level),
		.ch_pin_out(ch_pin_out), .ch_pin_oe_n(ch_pin_oe_n), .ch_irq(ch_irq));

	tcc_pin_model #(.NUM_CH(4)) u_pins (.ch_pin_out(ch_pin_out),
		.ch_pin_oe_n(ch_pin_oe_n), .ext_level(ext_level), .pin_level(pin_level));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ****************************************************************
	// Bus and compare tasks
	// ****************************************************************
	task automatic close_out();
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Idle edge first, so psel never gets two values in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rchk

	function automatic logic [7:0] cha(input int ch, input logic [3:0] sub);
		return `TCC_OFF_CH_BASE + 8'(ch << `TCC_CH_STRIDE_SHIFT) + {4'h0, sub};
	endfunction : cha

	// Run the counter until the channel flag shows, then halt it again
	task automatic run_to_flag(input int ch);
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h00);
		for (int n = 0; n < 40 && q[7] !== 1'b1; n++)
			apb(1'b0, cha(ch, `TCC_SUB_STATUS), 8'h00);
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h20);
		repeat (3) @(posedge pclk);
	endtask : run_to_flag

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, break_active, ext_clk} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		ext_level = 4'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`TCC_OFF_TIMER_CTRL, 8'h20);
		rchk(cha(0, `TCC_SUB_STATUS), 8'h00);
		rchk(cha(0, `TCC_SUB_VALUE_LO), 8'h00);
		rchk(8'h14, 8'h00);
		chk(last_err, 1'b1);
		apb(1'b1, `TCC_OFF_MOD_HI, 8'h00);
		apb(1'b1, `TCC_OFF_MOD_LO, 8'h3f);
		// Unbuffered compare, every pin action, irq on odd codes only
		for (int e = 0; e < 4; e++)
		begin
			cfg = {1'b0, e[0], 2'b01, e[1:0], 2'b00};
			apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h30);
			apb(1'b1, cha(0, `TCC_SUB_STATUS), cfg);
			apb(1'b1, cha(0, `TCC_SUB_VALUE_HI), 8'h00);
			apb(1'b1, cha(0, `TCC_SUB_VALUE_LO), 8'h10);
			repeat (3) @(posedge pclk);
			pin_before = pin_level[0];
			run_to_flag(0);
			rchk(cha(0, `TCC_SUB_STATUS), cfg | 8'h80);
			chk(ch_pin_oe_n[0], e == 0);
			if (e == 0)
				chk(ch_pin_out[0], 1'b0);
			else
				chk(ch_pin_out[0], e == 1 ? !pin_before : e == 3);
			chk(ch_irq[0], e[0]);
			apb(1'b1, cha(0, `TCC_SUB_STATUS), cfg | 8'h80);
			apb(1'b1, cha(0, `TCC_SUB_STATUS), cfg);
			rchk(cha(0, `TCC_SUB_STATUS), cfg | 8'h80);
			apb(1'b1, cha(0, `TCC_SUB_STATUS), cfg);
			rchk(cha(0, `TCC_SUB_STATUS), cfg);
			apb(1'b1, cha(0, `TCC_SUB_STATUS), cfg | 8'h80);
			rchk(cha(0, `TCC_SUB_STATUS), cfg);
			chk(ch_irq[0], 1'b0);
		end
		// Capture on channel 1, each edge selection
		for (int e = 1; e < 4; e++)
		begin
			cfg = {4'h4, e[1:0], 2'b00};
			apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h30);
			apb(1'b1, cha(1, `TCC_SUB_STATUS), cfg);
			apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h00);
			apb(1'b0, cha(1, `TCC_SUB_STATUS), 8'h00);
			apb(1'b1, cha(1, `TCC_SUB_STATUS), cfg);
			ext_level[1] <= 1'b1;
			repeat (6) @(posedge pclk);
			rchk(cha(1, `TCC_SUB_STATUS), {e[0], cfg[6:0]});
			apb(1'b1, cha(1, `TCC_SUB_STATUS), cfg);
			ext_level[1] <= 1'b0;
			repeat (6) @(posedge pclk);
			rchk(cha(1, `TCC_SUB_STATUS), {e[1], cfg[6:0]});
			apb(1'b1, cha(1, `TCC_SUB_STATUS), cfg);
		end
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h20);
		ext_level[1] <= 1'b1;
		repeat (6) @(posedge pclk);
		rchk(cha(1, `TCC_SUB_STATUS), cfg);
		// High byte read holds off captures until the low byte is read
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h00);
		rchk(cha(1, `TCC_SUB_VALUE_HI), 8'h00);
		ext_level[1] <= 1'b0;
		repeat (6) @(posedge pclk);
		rchk(cha(1, `TCC_SUB_STATUS), cfg);
		apb(1'b0, cha(1, `TCC_SUB_VALUE_LO), 8'h00);
		ext_level[1] <= 1'b1;
		repeat (6) @(posedge pclk);
		rchk(cha(1, `TCC_SUB_STATUS), cfg | 8'h80);
		apb(1'b1, cha(1, `TCC_SUB_STATUS), cfg);
		// Buffered even channel takes the odd pin away
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h30);
		apb(1'b1, cha(1, `TCC_SUB_STATUS), 8'h34);
		rchk(cha(1, `TCC_SUB_STATUS), 8'h14);
		repeat (3) @(posedge pclk);
		chk(ch_pin_oe_n[1], 1'b0);
		apb(1'b1, cha(0, `TCC_SUB_STATUS), 8'h24);
		repeat (3) @(posedge pclk);
		chk(ch_pin_oe_n[1], 1'b1);
		chk(ch_pin_oe_n[0], 1'b0);
		// Overflow toggle beats a match at the same count; full duty waits a period
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h30);
		apb(1'b1, cha(2, `TCC_SUB_STATUS), 8'h1e);
		apb(1'b1, cha(2, `TCC_SUB_VALUE_HI), 8'h00);
		apb(1'b1, cha(2, `TCC_SUB_VALUE_LO), 8'h3f);
		run_to_flag(2);
		chk(ch_pin_out[2], 1'b0);
		rchk(cha(2, `TCC_SUB_STATUS), 8'h9e);
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h00);
		repeat (70) @(posedge pclk);
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h20);
		apb(1'b1, cha(2, `TCC_SUB_STATUS), 8'h1f);
		rchk(cha(2, `TCC_SUB_STATUS), 8'h9f);
		apb(1'b1, cha(2, `TCC_SUB_STATUS), 8'h1f);
		run_to_flag(2);
		chk(ch_pin_out[2], 1'b1);
		apb(1'b1, cha(2, `TCC_SUB_STATUS), 8'h1e);
		chk(ch_pin_out[2], 1'b1);
		run_to_flag(2);
		apb(1'b1, cha(2, `TCC_SUB_STATUS), 8'h1e);
		run_to_flag(2);
		chk(ch_pin_out[2], 1'b0);
		// Pending high byte write keeps a full period free of matches
		apb(1'b1, cha(2, `TCC_SUB_STATUS), 8'h1e);
		apb(1'b1, cha(2, `TCC_SUB_VALUE_HI), 8'h00);
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h00);
		repeat (70) @(posedge pclk);
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h20);
		rchk(cha(2, `TCC_SUB_STATUS), 8'h1e);
		apb(1'b1, cha(2, `TCC_SUB_VALUE_LO), 8'h3f);
		// Each rising external clock edge advances the count once
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h37);
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h07);
		repeat (3)
		begin
			ext_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_clk <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		rchk(`TCC_OFF_COUNT_LO, 8'h03);
		// Break freezes the count
		apb(1'b1, `TCC_OFF_TIMER_CTRL, 8'h00);
		break_active <= 1'b1;
		apb(1'b0, `TCC_OFF_COUNT_LO, 8'h00);
		q2 = q;
		repeat (5) @(posedge pclk);
		rchk(`TCC_OFF_COUNT_LO, q2);
		break_active <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, `TCC_OFF_COUNT_LO, 8'h00);
		chk({7'h00, q != q2}, 8'h01);
		chk({7'h00, q <= 8'h3f}, 8'h01);
		close_out();
	end

	// Whole run needs on the order of a thousand cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		close_out();
	end
endmodule : tb_top
